/* File: src/bank_timing_trim_regs.sv */
// register bank of per-bank sampling time trims and timestamp lsb control
// assumes an avalon-mm master on clk, fuse defaults present at reset
// How it works
// - bank0 uses phase0 trim in dual mode
// - bank0 uses phase90 trim in single mode
// - bank1 uses phase0 trim in dual mode
// - bank1 uses phase90 trim in single mode
// - bank4 uses its phase0 trim always
// - bank5 uses its phase0 trim always
// - trims are rw bytes loaded from fuses
// - lsb control register resets to zero
// - timestamp replaces sample lsb, latency matched
`timescale 1ns/10ps
module bank_timing_trim_regs (
   input  wire logic                  clk,                 // 200 MHz clock
   input  wire logic                  rst_b,               // async reset, active low
   input  wire logic [11:0]           avs_address,         // byte address
   input  wire logic                  avs_read,            // read request
   input  wire logic                  avs_write,           // write request
   input  wire logic [3:0]            avs_byteenable,      // byte lanes
   input  wire logic [31:0]           avs_writedata,       // write data
   output logic [31:0]                avs_readdata,        // read data
   output logic                       avs_waitrequest,     // stall request
   output logic [1:0]                 avs_response,        // 00 ok, 10 slave error
   input  wire logic [7:0]            fuse_bank0_phase0,   // fuse default
   input  wire logic [7:0]            fuse_bank0_phase90,  // fuse default
   input  wire logic [7:0]            fuse_bank1_phase0,   // fuse default
   input  wire logic [7:0]            fuse_bank1_phase90,  // fuse default
   input  wire logic [7:0]            fuse_bank4_phase0,   // fuse default
   input  wire logic [7:0]            fuse_bank5_phase0,   // fuse default
   input  wire logic                  single_channel_mode, // 1 single, 0 dual
   input  wire logic                  timestamp_in,        // raw timestamp
   input  wire logic [11:0]           sample_in,           // sample, already delayed
   output logic [11:0]                sample_out,          // sample with lsb option
   output logic [7:0]                 bank0_timing,        // applied trim bank0
   output logic [7:0]                 bank1_timing,        // applied trim bank1
   output logic [7:0]                 bank4_timing,        // applied trim bank4
   output logic [7:0]                 bank5_timing         // applied trim bank5
);
   logic [7:0]            trim [trim_pkg::NUM_TRIM];
   logic [7:0]            trim_fuse [trim_pkg::NUM_TRIM];
   logic [7:0]            timestamp_lsb_control;
   logic                  timestamp_output_enable;
   logic                  load_pulse;
   logic                  mode_meta;
   logic                  mode_sync;
   logic                  ts_meta;
   logic                  ts_sync;
   logic                  ts_aligned;
   logic                  answered;
   logic                  req;
   trim_pkg::reg_sel_t    sel;
   logic [7:0]            wbyte;

   // index decode, shared by read and write paths
   function automatic trim_pkg::reg_sel_t decode(input logic [9:0] idx);
      case (idx)
         trim_pkg::IDX_BANK0_PHASE0:  decode = trim_pkg::SEL_B0P0;
         trim_pkg::IDX_BANK0_PHASE90: decode = trim_pkg::SEL_B0P90;
         trim_pkg::IDX_BANK1_PHASE0:  decode = trim_pkg::SEL_B1P0;
         trim_pkg::IDX_BANK1_PHASE90: decode = trim_pkg::SEL_B1P90;
         trim_pkg::IDX_BANK4_PHASE0:  decode = trim_pkg::SEL_B4P0;
         trim_pkg::IDX_BANK5_PHASE0:  decode = trim_pkg::SEL_B5P0;
         trim_pkg::IDX_TS_LSB_CTRL:   decode = trim_pkg::SEL_LSB;
         default:                     decode = trim_pkg::SEL_NONE;
      endcase
   endfunction

   assign sel   = decode(avs_address[11:2]);
   assign req   = avs_read | avs_write;
   assign wbyte = avs_writedata[7:0];

   assign trim_fuse[0] = fuse_bank0_phase0;
   assign trim_fuse[1] = fuse_bank0_phase90;
   assign trim_fuse[2] = fuse_bank1_phase0;
   assign trim_fuse[3] = fuse_bank1_phase90;
   assign trim_fuse[4] = fuse_bank4_phase0;
   assign trim_fuse[5] = fuse_bank5_phase0;

   fuse_loader u_fuse_loader (
      .clk        (clk),
      .rst_b      (rst_b),
      .load_pulse (load_pulse)
   );

   // one wait state per access: answer on the second cycle of a request
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         answered <= 1'b0;
      end else begin
         answered <= req & !answered;
      end
   end

   assign avs_waitrequest = req & !answered;

   // trim storage; fuse load after reset, bus writes after that
   generate
      for (genvar i = 0; i < trim_pkg::NUM_TRIM; i++) begin : g_trim
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               trim[i] <= 8'h00;
            end else if (load_pulse) begin
               trim[i] <= trim_fuse[i];
            end else if (avs_write && answered && avs_byteenable[0] && (sel == trim_pkg::reg_sel_t'(i))) begin
               trim[i] <= wbyte;
            end
         end
      end
   endgenerate

   // lsb control; reserved bits are stored as written
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         timestamp_lsb_control <= trim_pkg::RST_TS_LSB_CTRL;
      end else if (avs_write && answered && avs_byteenable[0] && sel == trim_pkg::SEL_LSB) begin
         timestamp_lsb_control <= wbyte;
      end
   end

   assign timestamp_output_enable = timestamp_lsb_control[trim_pkg::TS_EN_BIT];

   // read data and response, registered at the edge that ends the wait state, one edge before the answering edge
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         avs_readdata <= 32'h0000_0000;
         avs_response <= 2'b00;
      end else if (req && !answered) begin
         avs_response <= (sel == trim_pkg::SEL_NONE) ? 2'b10 : 2'b00;
         case (sel)
            trim_pkg::SEL_LSB:  avs_readdata <= {24'h00_0000, timestamp_lsb_control};
            trim_pkg::SEL_NONE: avs_readdata <= 32'h0000_0000;
            default:            avs_readdata <= {24'h00_0000, trim[sel]};
         endcase
      end
   end

   // mode comes from another domain: two flops before use
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mode_meta <= 1'b0;
         mode_sync <= 1'b0;
         ts_meta   <= 1'b0;
         ts_sync   <= 1'b0;
      end else begin
         mode_meta <= single_channel_mode;
         mode_sync <= mode_meta;
         ts_meta   <= timestamp_in;
         ts_sync   <= ts_meta;
      end
   end

   // applied trims, registered so mode changes switch glitch free
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bank0_timing <= 8'h00;
         bank1_timing <= 8'h00;
         bank4_timing <= 8'h00;
         bank5_timing <= 8'h00;
      end else begin
         bank0_timing <= mode_sync ? trim[1] : trim[0];
         bank1_timing <= mode_sync ? trim[3] : trim[2];
         bank4_timing <= trim[4];
         bank5_timing <= trim[5];
      end
   end

   // timestamp delayed to match the sample path
   ts_delay u_ts_delay (
      .clk   (clk),
      .rst_b (rst_b),
      .din   (ts_sync),
      .dout  (ts_aligned)
   );

   // lsb replacement; sample_in is assumed aligned to the delay above
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sample_out <= 12'h000;
      end else if (timestamp_output_enable) begin
         sample_out <= {sample_in[11:1], ts_aligned};
      end else begin
         sample_out <= sample_in;
      end
   end
endmodule

/* File: src/trim_pkg.sv */
// constants for the bank timing trim register bank
// assumes an avalon-mm slave with 32-bit data, word aligned registers
package trim_pkg;
   // printed offsets are not multiples of four: they are word indices
   localparam int          ADDR_W             = 10;
   localparam logic [9:0]  IDX_BANK0_PHASE0   = 10'h102;
   localparam logic [9:0]  IDX_BANK0_PHASE90  = 10'h103;
   localparam logic [9:0]  IDX_BANK1_PHASE0   = 10'h112;
   localparam logic [9:0]  IDX_BANK1_PHASE90  = 10'h113;
   localparam logic [9:0]  IDX_BANK4_PHASE0   = 10'h142;
   localparam logic [9:0]  IDX_BANK5_PHASE0   = 10'h152;
   localparam logic [9:0]  IDX_TS_LSB_CTRL    = 10'h160;
   localparam logic [7:0]  RST_TS_LSB_CTRL    = 8'h00;
   localparam int          TS_EN_BIT          = 0;
   localparam int          NUM_TRIM           = 6;
   localparam int          SAMPLE_W           = 12;
   // analog input path latency, in clock cycles
   localparam int          PATH_LATENCY       = 4;
   typedef enum logic [2:0] {
      SEL_B0P0,
      SEL_B0P90,
      SEL_B1P0,
      SEL_B1P90,
      SEL_B4P0,
      SEL_B5P0,
      SEL_LSB,
      SEL_NONE
   } reg_sel_t;
endpackage

/* File: src/fuse_loader.sv */
// captures fuse defaults after reset release
// assumes fuse values are stable from reset onward
`timescale 1ns/10ps
module fuse_loader (
   input  wire logic        clk,        // system clock
   input  wire logic        rst_b,      // async reset, active low
   output logic             load_pulse  // one-cycle pulse after release
);
   logic done;

   // strap style capture: flops reset to constants, load one cycle later
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         done       <= 1'b0;
         load_pulse <= 1'b0;
      end else begin
         done       <= 1'b1;
         load_pulse <= !done;
      end
   end
endmodule

/* File: src/ts_delay.sv */
// delay line that keeps the timestamp aligned with the sample path
// assumes timestamp input is on the core clock
`timescale 1ns/10ps
module ts_delay (
   input  wire logic clk,     // system clock
   input  wire logic rst_b,   // async reset, active low
   input  wire logic din,     // undelayed timestamp
   output logic      dout     // timestamp after path latency
);
   logic [trim_pkg::PATH_LATENCY-1:0] pipe;

   // shift register, one stage per cycle of sample latency
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pipe <= '0;
      end else begin
         pipe <= {pipe[trim_pkg::PATH_LATENCY-2:0], din};
      end
   end

   assign dout = pipe[trim_pkg::PATH_LATENCY-1];
endmodule

/* File: verif/trim_regs_properties.sv */
// checker: bus handshake, applied trims, sample path
// assumes a bind onto bank_timing_trim_regs, one clock
`timescale 1ns/10ps
module trim_regs_properties (
   input wire logic        clk,                 // clock
   input wire logic        rst_b,               // reset
   input wire logic [11:0] avs_address,         // address
   input wire logic        avs_read,            // read
   input wire logic        avs_write,           // write
   input wire logic        avs_waitrequest,     // stall
   input wire logic [1:0]  avs_response,        // response
   input wire logic        single_channel_mode, // mode
   input wire logic [11:0] sample_in,           // sample
   input wire logic [11:0] sample_out,          // sample
   input wire logic [7:0]  bank0_timing,        // trim
   input wire logic [7:0]  bank1_timing,        // trim
   input wire logic [7:0]  bank4_timing,        // trim
   input wire logic [7:0]  bank5_timing         // trim
);
   logic [2:0] age;
   wire        cmt = avs_write && !avs_waitrequest;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // cycles since reset, masks the fuse load
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b)
         age <= 3'h0;
      else if (age != 3'h7)
         age <= age + 3'h1;
   end
   AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("stall too long");
   AST_MAP_OK: assert property (cmt && avs_address[11:2] == trim_pkg::IDX_TS_LSB_CTRL |-> avs_response == 2'h0)
      else $error("bad response");
   AST_UNMAP: assert property (!avs_waitrequest && avs_read && avs_address == 12'h000 |-> avs_response == 2'h2)
      else $error("unmapped accepted");
   AST_B0: assert property (age == 3'h7 && !$past(cmt, 2) && $past(single_channel_mode, 3) == $past(single_channel_mode, 4)
      |-> $stable(bank0_timing)) else $error("bank0 moved");
   AST_B1: assert property (age == 3'h7 && !$past(cmt, 2) && $past(single_channel_mode, 3) == $past(single_channel_mode, 4)
      |-> $stable(bank1_timing)) else $error("bank1 moved");
   AST_B4: assert property (age == 3'h7 && !$past(cmt, 2) |-> $stable(bank4_timing)) else $error("bank4 moved");
   AST_B5: assert property (age == 3'h7 && !$past(cmt, 2) |-> $stable(bank5_timing)) else $error("bank5 moved");
   AST_SAMPLE: assert property (age == 3'h7 |-> sample_out[11:1] == $past(sample_in[11:1]))
      else $error("sample skew");
   cover property (cmt);
   cover property ($rose(single_channel_mode));
   cover property (avs_response == 2'h2);
endmodule

/* File: verif/bank_timing_trim_regs_tb.sv */
// bench for the trim bank: registers, mode selection, timestamp lsb
// assumes the checker is compiled first
`timescale 1ns/10ps
module bank_timing_trim_regs_tb;
   logic        clk, rst_b, avs_read, avs_write, avs_waitrequest, single_channel_mode, timestamp_in, th [40];
   logic [11:0] avs_address, sample_in, sample_out, sh [40];
   logic [31:0] avs_writedata, avs_readdata, rdat;
   logic [3:0]  avs_byteenable;
   logic [1:0]  avs_response, resp;
   logic [7:0]  bank0_timing, bank1_timing, bank4_timing, bank5_timing, m [7], fz [6];
   int          n_errors = 0, total_checks = 0, i, k, md;
   wire  [7:0]  fuse_bank0_phase0 = fz[0], fuse_bank0_phase90 = fz[1], fuse_bank1_phase0 = fz[2];
   wire  [7:0]  fuse_bank1_phase90 = fz[3], fuse_bank4_phase0 = fz[4], fuse_bank5_phase0 = fz[5];
   localparam logic [9:0] IX [7] = '{trim_pkg::IDX_BANK0_PHASE0, trim_pkg::IDX_BANK0_PHASE90,
      trim_pkg::IDX_BANK1_PHASE0, trim_pkg::IDX_BANK1_PHASE90, trim_pkg::IDX_BANK4_PHASE0,
      trim_pkg::IDX_BANK5_PHASE0, trim_pkg::IDX_TS_LSB_CTRL};
   bank_timing_trim_regs bank_timing_trim_regs_i (.clk, .rst_b, .avs_address, .avs_read, .avs_write,
      .avs_byteenable, .avs_writedata, .avs_readdata, .avs_waitrequest, .avs_response, .fuse_bank0_phase0,
      .fuse_bank0_phase90, .fuse_bank1_phase0, .fuse_bank1_phase90, .fuse_bank4_phase0, .fuse_bank5_phase0,
      .single_channel_mode, .timestamp_in, .sample_in, .sample_out, .bank0_timing, .bank1_timing,
      .bank4_timing, .bank5_timing);
   initial begin
      clk = 1'h0;
      forever #2.5 clk = ~clk;
   end
   // applied trim per bank for a given mode
   function automatic logic [7:0] exp_t(input int b, input int s);
      case (b)
         0: return s ? m[1] : m[0];
         1: return s ? m[3] : m[2];
         2: return m[4];
         default: return m[5];
      endcase
   endfunction
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", s, exp, seen);
      end
   endtask
   // one access; waitrequest sampled at the rising edge, where the commit happens
   task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
      int n;
      avs_address <= {a, 2'h0};
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'h0 && n < 50);
      if (n >= 50) begin
         n_errors++;
         wrap_up();
      end
      rdat = avs_readdata;
      resp = avs_response;
      avs_read <= 1'h0;
      avs_write <= 1'h0;
      @(posedge clk);
   endtask
   initial begin
      void'($urandom(3503));
      foreach (fz[j]) fz[j] = 8'($urandom);
      foreach (fz[j]) m[j] = fz[j];
      {rst_b, avs_read, avs_write, single_channel_mode, timestamp_in} = 5'h00;
      {avs_address, sample_in, avs_writedata, avs_byteenable} = {56'h0, 4'h1};
      repeat (12) @(posedge clk);
      rst_b <= 1'h1;
      repeat (4) @(posedge clk);
      for (i = 0; i < 6; i++) begin
         bus(0, IX[i], 0);
         chk("fuse", rdat, 32'(m[i]));
      end
      bus(0, IX[6], 0);
      chk("lsb_reset", rdat, 32'h0000_0000);
      $display("test reset done");
      for (k = 0; k < 8; k++) begin
         for (i = 0; i < 6; i++) begin
            m[i] = 8'($urandom);
            bus(1, IX[i], {24'($urandom), m[i]});
         end
         for (i = 0; i < 6; i++) begin
            bus(0, IX[i], 0);
            chk("readback", rdat, 32'(m[i]));
         end
         md = k % 2;
         single_channel_mode <= md[0];
         repeat (6) @(posedge clk);
         chk("bank0", 32'(bank0_timing), 32'(exp_t(0, md)));
         chk("bank1", 32'(bank1_timing), 32'(exp_t(1, md)));
         chk("bank4", 32'(bank4_timing), 32'(exp_t(2, md)));
         chk("bank5", 32'(bank5_timing), 32'(exp_t(3, md)));
      end
      $display("test trims done");
      avs_byteenable <= 4'h0;
      bus(1, IX[4], 32'(~m[4]));
      avs_byteenable <= 4'h1;
      bus(0, IX[4], 0);
      chk("lane_off", rdat, 32'(m[4]));
      bus(1, 10'h000, 32'h0000_00ff);
      bus(0, 10'h000, 0);
      chk("unmapped", {rdat[29:0], resp}, 32'h0000_0002);
      $display("test refusals done");
      for (md = 0; md < 2; md++) begin
         m[6] = {7'($urandom), md[0]};
         bus(1, IX[6], 32'(m[6]));
         bus(0, IX[6], 0);
         chk("lsb_ctrl", rdat, 32'(m[6]));
         for (k = 0; k < 40; k++) begin
            @(posedge clk);
            sh[k] = 12'($urandom);
            th[k] = 1'($urandom);
            sample_in <= sh[k];
            timestamp_in <= th[k];
            @(negedge clk);
            if (k >= 8)
               chk("sample", 32'(sample_out), 32'({sh[k-1][11:1], md[0] ? th[k-7] : sh[k-1][0]}));
         end
      end
      $display("test timestamp done");
      wrap_up();
   end
endmodule
bind bank_timing_trim_regs trim_regs_properties chk_i (.clk, .rst_b, .avs_address, .avs_read, .avs_write,
   .avs_waitrequest, .avs_response, .single_channel_mode, .sample_in, .sample_out, .bank0_timing,
   .bank1_timing, .bank4_timing, .bank5_timing);
